// ==== bench/lcd_panel_output_interface_tb_top.sv ====
// self-checking bench for the lcd panel output interface
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_output_interface_tb_top;
  import lpo_pkg::*;
  typedef struct {lpo_fmt_e fmt; logic [1:0] mux; lpo_bus_e bus; int per; int plen; logic [31:0] pat;} lpo_row_s;
  localparam logic [23:0] PNL_RD = 24'h5a3c96;
  localparam logic [7:0] PNL_RB = 8'hc5;
  logic clk_sys, clk_pix, rst = 1'b1;
  logic [23:0] pix_data = 24'h0, dbi_wdata = 24'h0;
  logic pix_de = 0, pix_hs = 0, pix_vs = 0, pix_fodd = 0, pix_ilace = 0, pix_lodd = 0;
  lpo_fmt_e cfg_fmt = LPO_FMT_PAR;
  lpo_bus_e cfg_bus = LPO_BUS_24;
  logic [1:0] cfg_mux = 2'h0;
  logic cfg_sel = 0, cfg_tb = 0, cfg_4w = 0, dbi_req = 0, dbi_rd = 0, dbi_dc = 0, spi_req = 0, spi_rd = 0;
  logic [15:0] spi_wdata = 16'h0, spi_rdata, pnl_sword;
  logic [23:0] lcd_data, dbi_rdata, dbi_dout, dbi_din, pnl_d, pnl_word;
  logic pix_ready, lcd_de, lcd_hs, lcd_vs, cs0_n, cs1_n, dbi_ack, dbi_oe, dbi_dco, dbi_wr, dbi_rdo;
  logic spi_busy, spi_sck, spi_cs_n, spi_dco, spi_sdo, spi_oe, spi_sdi, pnl_sda;
  logic [4:0] pnl_cnt;
  logic [31:0] hist;
  logic got, hit;
  logic [23:0] rdat;
  int error_cnt = 0, checks = 0, last, per, den, c0, c1;
  lpo_row_s rows [11] = '{
    '{LPO_FMT_PAR, 2'h0, LPO_BUS_24, 1, 1, 32'h00112233},
    '{LPO_FMT_PAR, 2'h1, LPO_BUS_18, 2, 0, 32'h0},
    '{LPO_FMT_PAR, 2'h2, LPO_BUS_16, 3, 0, 32'h0},
    '{LPO_FMT_PAR, 2'h3, LPO_BUS_12, 4, 0, 32'h0},
    '{LPO_FMT_SER3, 2'h0, LPO_BUS_8, 3, 3, 32'h00112233},
    '{LPO_FMT_SER4, 2'h0, LPO_BUS_8, 4, 4, 32'h11223300},
    '{LPO_FMT_CCIR656, 2'h0, LPO_BUS_8, 2, 0, 32'h0},
    '{LPO_FMT_CCIR601, 2'h0, LPO_BUS_24, 3, 0, 32'h0},
    '{LPO_FMT_PAR, 2'h0, LPO_BUS_18, 1, 1, 32'h0000420c},
    '{LPO_FMT_PAR, 2'h0, LPO_BUS_16, 1, 1, 32'h00001106},
    '{LPO_FMT_PAR, 2'h0, LPO_BUS_12, 1, 1, 32'h00000123}};
  // shared two-way lines: the dut drives while its enable is set, the panel model otherwise
  assign dbi_din = dbi_oe ? dbi_dout : pnl_d;
  assign spi_sdi = spi_oe ? spi_sdo : pnl_sda;
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // offset keeps pixel edges off system edges
  initial begin
    clk_pix = 1'b0;
    #13;
    forever #40 clk_pix = ~clk_pix;
  end
  lpo_panel_out dut_u (.clk_sys_in(clk_sys), .rst_in(rst), .clk_pix_in(clk_pix), .pix_data_in(pix_data),
    .pix_de_in(pix_de), .pix_hsync_in(pix_hs), .pix_vsync_in(pix_vs), .pix_field_odd_in(pix_fodd),
    .pix_interlace_in(pix_ilace), .pix_line_odd_in(pix_lodd), .pix_ready_out(pix_ready), .cfg_fmt_in(cfg_fmt),
    .cfg_bus_in(cfg_bus), .cfg_mux_in(cfg_mux), .cfg_panel_sel_in(cfg_sel), .cfg_dbi_type_b_in(cfg_tb),
    .cfg_spi_4wire_in(cfg_4w), .lcd_data_out(lcd_data), .lcd_de_out(lcd_de), .lcd_hsync_out(lcd_hs),
    .lcd_vsync_out(lcd_vs), .lcd_cs0_n_out(cs0_n), .lcd_cs1_n_out(cs1_n), .dbi_req_in(dbi_req), .dbi_rd_in(dbi_rd),
    .dbi_dc_in(dbi_dc), .dbi_wdata_in(dbi_wdata), .dbi_ack_out(dbi_ack), .dbi_rdata_out(dbi_rdata),
    .dbi_d_in(dbi_din), .dbi_d_out(dbi_dout), .dbi_d_oe_out(dbi_oe), .dbi_dc_out(dbi_dco), .dbi_wr_out(dbi_wr),
    .dbi_rd_out(dbi_rdo), .spi_req_in(spi_req), .spi_rd_in(spi_rd), .spi_wdata_in(spi_wdata),
    .spi_busy_out(spi_busy), .spi_rdata_out(spi_rdata), .spi_sck_out(spi_sck), .spi_cs_n_out(spi_cs_n),
    .spi_dc_out(spi_dco), .spi_sda_in(spi_sdi), .spi_sda_out(spi_sdo), .spi_sda_oe_out(spi_oe));
  lpo_panel_model #(.RD_WORD(PNL_RD), .RD_BYTE(PNL_RB)) pnl_u (.dbi_rd_n_in(dbi_rdo), .dbi_wr_n_in(dbi_wr),
    .dbi_d_in(dbi_din), .dbi_d_out(pnl_d), .sck_in(spi_sck), .cs_n_in(spi_cs_n), .sda_in(spi_sdi),
    .sda_out(pnl_sda), .wr_word_out(pnl_word), .spi_word_out(pnl_sword), .spi_cnt_out(pnl_cnt));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic vpulse();
    repeat (2) @(negedge clk_pix);
    pix_vs = 1'b1;
    repeat (3) @(negedge clk_pix);
    pix_vs = 1'b0;
  endtask : vpulse
  task automatic line();
    den = 0;
    c0 = 0;
    c1 = 0;
    @(negedge clk_pix) pix_de = 1'b1;
    repeat (10) begin
      @(negedge clk_pix);
      den += int'(lcd_de === 1'b1);
      c0 += int'(cs0_n === 1'b0);
      c1 += int'(cs1_n === 1'b0);
    end
    pix_de = 1'b0;
    repeat (3) @(negedge clk_pix);
  endtask : line
  // request held until the ack edge, data taken at that edge
  task automatic dbi_xfer(input logic rd, input logic [23:0] wd);
    got = 1'b0;
    @(negedge clk_sys) dbi_req = 1'b1;
    dbi_rd = rd;
    dbi_dc = ~rd;
    dbi_wdata = wd;
    repeat (40) begin
      @(posedge clk_sys);
      if (dbi_ack === 1'b1) begin
        got = 1'b1;
        rdat = dbi_rdata;
        break;
      end
    end
    @(negedge clk_sys) dbi_req = 1'b0;
  endtask : dbi_xfer
  task automatic spi_xfer(input logic rd, input logic [15:0] wd);
    int n;
    @(negedge clk_sys) spi_req = 1'b1;
    spi_rd = rd;
    spi_wdata = wd;
    repeat (10) begin
      @(posedge clk_sys);
      if (spi_busy === 1'b1) break;
    end
    @(negedge clk_sys) spi_req = 1'b0;
    n = 0;
    while (spi_busy !== 1'b0 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    chk("spi done in time", 1, n < 400);
  endtask : spi_xfer
  task automatic give_verdict();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    #100000;
    error_cnt++;
    $display("[ERR] watchdog expected finish seen hang");
    give_verdict();
  end
  initial begin
    // reset spans slow clock so both domains see it
    repeat (4) @(negedge clk_pix);
    chk("reset pins", 32'h78, {25'h0, cs0_n, cs1_n, dbi_wr, dbi_rdo, dbi_oe, spi_busy, lcd_de});
    repeat (4) @(negedge clk_pix);
    rst = 1'b0;
    repeat (3) @(negedge clk_pix);
    for (int i = 0; i < 11; i++) begin
      @(negedge clk_sys) cfg_fmt = rows[i].fmt;
      cfg_mux = rows[i].mux;
      cfg_bus = rows[i].bus;
      vpulse();
      @(negedge clk_pix) pix_de = 1'b1;
      pix_data = 24'h112233;
      last = -1;
      per = 0;
      hit = 1'b0;
      for (int k = 0; k < 24; k++) begin
        @(negedge clk_pix);
        // mid-line change must wait for the next frame
        if (k == 6) cfg_mux = ~rows[i].mux;
        if (pix_ready === 1'b1) begin
          if (last >= 0) per = k - last;
          last = k;
        end
        hist = {hist[23:0], lcd_data[7:0]};
        if (rows[i].plen == 3 && hist[23:0] === rows[i].pat[23:0]) hit = 1'b1;
        if (rows[i].plen == 4 && hist === rows[i].pat) hit = 1'b1;
        if (rows[i].plen == 1 && lcd_data === rows[i].pat[23:0]) hit = 1'b1;
      end
      pix_de = 1'b0;
      cfg_mux = rows[i].mux;
      chk("beats per pixel", rows[i].per, per);
      if (rows[i].plen > 0) chk("beat data", 1, hit);
      repeat (3) @(negedge clk_pix);
    end
    @(negedge clk_sys) cfg_fmt = LPO_FMT_PAR;
    cfg_mux = 2'h0;
    cfg_bus = LPO_BUS_24;
    vpulse();
    pix_ilace = 1'b1;
    pix_fodd = 1'b1;
    line();
    chk("de even line odd field", 0, den);
    pix_lodd = 1'b1;
    line();
    chk("de odd line odd field", 1, den > 0);
    chk("idle panel select", 0, c1);
    chk("served panel select", 1, c0 > 0);
    pix_fodd = 1'b0;
    line();
    chk("de odd line even field", 0, den);
    pix_ilace = 1'b0;
    pix_lodd = 1'b0;
    line();
    chk("de progressive", 1, den > 0);
    pix_hs = 1'b1;
    @(negedge clk_pix) chk("hsync out", 1, lcd_hs);
    pix_hs = 1'b0;
    @(negedge clk_pix) chk("hsync idle", 0, lcd_hs);
    @(negedge clk_sys) cfg_sel = 1'b1;
    vpulse();
    line();
    chk("idle panel select", 0, c0);
    chk("served panel select", 1, c1 > 0);
    dbi_xfer(1'b0, 24'h0a0b0c);
    chk("dbi outside blanking", 0, got);
    @(negedge clk_pix) pix_vs = 1'b1;
    repeat (3) @(negedge clk_pix);
    chk("vsync out", 1, lcd_vs);
    for (int t = 0; t < 2; t++) begin
      @(negedge clk_sys) cfg_tb = t[0];
      repeat (4) @(negedge clk_sys);
      dbi_xfer(1'b0, 24'hf3e2d1 ^ t);
      chk("dbi write ack", 1, got);
      chk("dbi write word", 24'hf3e2d1 ^ t, pnl_word);
      chk("dbi dc write", 1, dbi_dco);
      dbi_xfer(1'b1, 24'h0);
      chk("dbi read word", PNL_RD, rdat);
      chk("dbi dc read", 0, dbi_dco);
    end
    @(negedge clk_pix) pix_vs = 1'b0;
    for (int w = 0; w < 2; w++) begin
      @(negedge clk_sys) cfg_4w = w[0];
      repeat (4) @(negedge clk_sys);
      spi_xfer(1'b0, 16'ha5c3);
      chk("spi word", 16'ha5c3, pnl_sword);
      chk("spi bit count", 16, pnl_cnt);
      chk("spi dc flag", w, spi_dco);
      spi_xfer(1'b1, 16'h8100);
      chk("spi read byte", PNL_RB, spi_rdata[7:0]);
    end
    // async reset mid-transfer: outputs drop at once, not at an edge
    @(negedge clk_pix) pix_de = 1'b1;
    @(negedge clk_sys) spi_req = 1'b1;
    repeat (3) @(negedge clk_sys);
    spi_req = 1'b0;
    @(negedge clk_pix);
    #3 rst = 1'b1;
    #0.5 chk("mid-run reset pins", 32'h78, {25'h0, cs0_n, cs1_n, dbi_wr, dbi_rdo, dbi_oe, spi_busy, lcd_de});
    repeat (8) @(negedge clk_pix);
    rst = 1'b0;
    repeat (3) @(negedge clk_pix);
    chk("de after reset", 1, lcd_de);
    give_verdict();
  end
endmodule : lcd_panel_output_interface_tb_top
`default_nettype wire

// ==== bench/lpo_panel_model.sv ====
// panel-side model: command bus panel and register port slave
`timescale 1ns/1ps
`default_nettype none
module lpo_panel_model #(
  parameter logic [23:0] RD_WORD = 24'h5a3c96,
  parameter logic [7:0] RD_BYTE = 8'hc5
) (
  input wire logic dbi_rd_n_in,
  input wire logic dbi_wr_n_in,
  input wire logic [23:0] dbi_d_in,
  output var logic [23:0] dbi_d_out,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic sda_in,
  output var logic sda_out,
  output var logic [23:0] wr_word_out,
  output var logic [15:0] spi_word_out,
  output var logic [4:0] spi_cnt_out
);
  logic [15:0] sh = 16'h0000;
  int n = 0;
  initial dbi_d_out = ~RD_WORD;
  initial sda_out = 1'b0;
  // ------------------------------------------------------------
  // command bus: released bus shows inverse of last value
  // ------------------------------------------------------------
  always @(dbi_rd_n_in) dbi_d_out = dbi_rd_n_in ? ~dbi_d_out : RD_WORD;
  always @(posedge dbi_wr_n_in) wr_word_out = dbi_d_in;
  // ------------------------------------------------------------
  // register port: answers only in the last eight bits
  // ------------------------------------------------------------
  always @(negedge cs_n_in) n = 0;
  always @(posedge sck_in) begin
    if (cs_n_in === 1'b0) begin
      sh = {sh[14:0], sda_in};
      n = n + 1;
    end
  end
  always @(negedge sck_in) begin
    if (cs_n_in === 1'b0 && n >= 8 && n < 16) sda_out = RD_BYTE[15 - n];
    else sda_out = ~sda_out;
  end
  always @(posedge cs_n_in) begin
    spi_word_out = sh;
    spi_cnt_out = n[4:0];
  end
endmodule : lpo_panel_model
`default_nettype wire

// ==== hdl/lpo_consts.svh ====
// constants for the lcd panel output interface
`ifndef LPO_CONSTS_SVH
`define LPO_CONSTS_SVH
`define LPO_DW 24
`define LPO_MAX_PCLK_MHZ 150
`define LPO_SYS_MHZ 250
`define LPO_SPI_DIV 4'h3
`define LPO_SPI_BITS 5'h10
`define LPO_DBI_HALF 3'h4
`define LPO_CNT_W 4
`endif

// ==== hdl/lpo_panel_out.sv ====
// lcd panel output interface: pixel stream, command bus and panel register port
`timescale 1ns/1ps
`default_nettype none
`include "lpo_consts.svh"
module lpo_panel_out #(
  parameter int DW = `LPO_DW
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic clk_pix_in,
  // stream from display engine, pixel clock domain
  input wire logic [DW-1:0] pix_data_in,
  input wire logic pix_de_in,
  input wire logic pix_hsync_in,
  input wire logic pix_vsync_in,
  input wire logic pix_field_odd_in,
  input wire logic pix_interlace_in,
  input wire logic pix_line_odd_in,
  output logic pix_ready_out,
  // configuration, sys domain
  input wire lpo_pkg::lpo_fmt_e cfg_fmt_in,
  input wire lpo_pkg::lpo_bus_e cfg_bus_in,
  input wire logic [1:0] cfg_mux_in,
  input wire logic cfg_panel_sel_in,
  input wire logic cfg_dbi_type_b_in,
  input wire logic cfg_spi_4wire_in,
  // panel pins, pixel domain
  output logic [DW-1:0] lcd_data_out,
  output logic lcd_de_out,
  output logic lcd_hsync_out,
  output logic lcd_vsync_out,
  output logic lcd_cs0_n_out,
  output logic lcd_cs1_n_out,
  // command bus pins, sys domain
  input wire logic dbi_req_in,
  input wire logic dbi_rd_in,
  input wire logic dbi_dc_in,
  input wire logic [DW-1:0] dbi_wdata_in,
  output logic dbi_ack_out,
  output logic [DW-1:0] dbi_rdata_out,
  input wire logic [DW-1:0] dbi_d_in,
  output logic [DW-1:0] dbi_d_out,
  output logic dbi_d_oe_out,
  output logic dbi_dc_out,
  output logic dbi_wr_out,
  output logic dbi_rd_out,
  // panel register port, sys domain
  input wire logic spi_req_in,
  input wire logic spi_rd_in,
  input wire logic [15:0] spi_wdata_in,
  output logic spi_busy_out,
  output logic [15:0] spi_rdata_out,
  output logic spi_sck_out,
  output logic spi_cs_n_out,
  output logic spi_dc_out,
  input wire logic spi_sda_in,
  output logic spi_sda_out,
  output logic spi_sda_oe_out
);
  import lpo_pkg::*;

  // -------------------------------------------------------------
  // configuration crossing into the pixel clock
  // -------------------------------------------------------------
  // config is quasi-static; each bit synced, latched at frame start
  localparam int CW = 9;
  logic [CW-1:0] cfg_s1, cfg_s2;
  always_ff @(posedge clk_pix_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_s1 <= '0;
      cfg_s2 <= '0;
    end else begin
      cfg_s1 <= {cfg_fmt_in, cfg_bus_in, cfg_mux_in, cfg_panel_sel_in};
      cfg_s2 <= cfg_s1;
    end
  end

  // stream sync inputs are from the engine in this domain; vsync to sys is a level
  logic vs_s1, vs_s2, dbi_busy_s1, dbi_busy_s2;
  // registered busy: the crossing never sees state decode glitches
  logic dbi_busy_q;

  // -------------------------------------------------------------
  // pixel stream serialiser
  // -------------------------------------------------------------
  logic [CW-1:0] cfg_act, next_cfg_act;
  logic [1:0] beat, next_beat;
  logic [1:0] beats_m1;
  logic [23:0] pix_hold, next_pix_hold;
  logic [DW-1:0] next_data;
  logic next_de, next_hs, next_vs, next_cs0_n, next_cs1_n, next_ready;
  logic vs_d, next_vs_d, line_ok;
  lpo_fmt_e fmt_a;
  lpo_bus_e bus_a;

  function automatic logic [DW-1:0] lpo_mask(input lpo_bus_e b, input logic [23:0] d);
    case (b)
      LPO_BUS_24: lpo_mask = d;
      LPO_BUS_18: lpo_mask = {6'h00, d[23:18], d[15:10], d[7:2]};
      LPO_BUS_16: lpo_mask = {8'h00, d[23:19], d[15:10], d[7:3]};
      LPO_BUS_12: lpo_mask = {12'h000, d[23:20], d[15:12], d[7:4]};
      default: lpo_mask = {16'h0000, d[7:0]};
    endcase
  endfunction : lpo_mask

  always_comb begin
    fmt_a = lpo_fmt_e'(cfg_act[8:6]);
    bus_a = lpo_bus_e'(cfg_act[5:3]);
    case (fmt_a)
      LPO_FMT_SER3: beats_m1 = 2'h2;
      LPO_FMT_SER4: beats_m1 = 2'h3;
      LPO_FMT_CCIR656: beats_m1 = 2'h1;
      LPO_FMT_CCIR601: beats_m1 = 2'h2;
      default: beats_m1 = cfg_act[2:1];
    endcase
  end

  always_comb begin
    next_vs_d = pix_vsync_in;
    next_cfg_act = cfg_act;
    if (pix_vsync_in && !vs_d) begin
      next_cfg_act = cfg_s2;
    end
    // only the field's parity of lines is shown in interlace
    line_ok = !pix_interlace_in || (pix_line_odd_in == pix_field_odd_in);
    next_beat = beat;
    next_pix_hold = pix_hold;
    next_ready = 1'b0;
    if (beat == 2'h0) begin
      next_pix_hold = pix_data_in[23:0];
      next_beat = (beats_m1 == 2'h0) ? 2'h0 : 2'h1;
      next_ready = (beats_m1 == 2'h0);
    end else if (beat == beats_m1) begin
      next_beat = 2'h0;
      next_ready = 1'b1;
    end else begin
      next_beat = beat + 2'h1;
    end
    next_data = '0;
    if (fmt_a == LPO_FMT_PAR) begin
      if (beats_m1 == 2'h0) begin
        next_data = lpo_mask(bus_a, pix_data_in[23:0]);
      end else begin
        // narrow bus: one byte lane per beat, msb colour first
        case (beat == 2'h0 ? 2'h0 : beat)
          2'h0: next_data = {16'h0000, pix_data_in[23:16]};
          2'h1: next_data = {16'h0000, pix_hold[15:8]};
          2'h2: next_data = {16'h0000, pix_hold[7:0]};
          default: next_data = '0;
        endcase
      end
    end else begin
      // serial and ccir formats drive only the low byte
      case (beat)
        2'h0: next_data = {16'h0000, pix_data_in[23:16]};
        2'h1: next_data = {16'h0000, pix_hold[15:8]};
        2'h2: next_data = {16'h0000, pix_hold[7:0]};
        default: next_data = '0;
      endcase
    end
    next_de = pix_de_in && line_ok;
    next_hs = pix_hsync_in;
    next_vs = pix_vsync_in;
    // inactive panel deselected; active one selected only with de and no synced command bus busy
    next_cs0_n = !(cfg_act[0] == 1'b0 && !dbi_busy_s2 && next_de);
    next_cs1_n = !(cfg_act[0] == 1'b1 && !dbi_busy_s2 && next_de);
  end

  always_ff @(posedge clk_pix_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_act <= '0;
      beat <= 2'h0;
      pix_hold <= '0;
      vs_d <= 1'b0;
      lcd_data_out <= '0;
      lcd_de_out <= 1'b0;
      lcd_hsync_out <= 1'b0;
      lcd_vsync_out <= 1'b0;
      lcd_cs0_n_out <= 1'b1;
      lcd_cs1_n_out <= 1'b1;
      pix_ready_out <= 1'b0;
      dbi_busy_s1 <= 1'b0;
      dbi_busy_s2 <= 1'b0;
    end else begin
      cfg_act <= next_cfg_act;
      beat <= next_beat;
      pix_hold <= next_pix_hold;
      vs_d <= next_vs_d;
      lcd_data_out <= next_data;
      lcd_de_out <= next_de;
      lcd_hsync_out <= next_hs;
      lcd_vsync_out <= next_vs;
      lcd_cs0_n_out <= next_cs0_n;
      lcd_cs1_n_out <= next_cs1_n;
      pix_ready_out <= next_ready;
      dbi_busy_s1 <= dbi_busy_q;
      dbi_busy_s2 <= dbi_busy_s1;
    end
  end

  // -------------------------------------------------------------
  // command bus through mode (sys domain)
  // -------------------------------------------------------------
  lpo_dbi_e dbi_state, next_dbi_state;
  logic [2:0] dbi_cnt, next_dbi_cnt;
  logic [DW-1:0] next_dbi_d, next_rdata;
  logic next_dbi_oe, next_dbi_dc, next_dbi_wr, next_dbi_rd, next_ack;
  logic dbi_rd_q, next_dbi_rd_q;
  // panel data pins pass two flops; strobe is long enough to cover them
  logic [DW-1:0] dbi_d_s1, dbi_d_s2;

  always_comb begin
    next_dbi_state = dbi_state;
    next_dbi_cnt = dbi_cnt;
    next_dbi_d = dbi_d_out;
    next_dbi_oe = dbi_d_oe_out;
    next_dbi_dc = dbi_dc_out;
    next_dbi_wr = 1'b1;
    next_dbi_rd = 1'b1;
    next_ack = 1'b0;
    next_rdata = dbi_rdata_out;
    next_dbi_rd_q = dbi_rd_q;
    case (dbi_state)
      LPO_DBI_IDLE: begin
        next_dbi_oe = 1'b0;
        if (dbi_req_in && vs_s2) begin
          next_dbi_state = LPO_DBI_SETUP;
          next_dbi_dc = dbi_dc_in;
          next_dbi_d = dbi_wdata_in;
          next_dbi_oe = !dbi_rd_in;
          next_dbi_rd_q = dbi_rd_in;
          next_dbi_cnt = `LPO_DBI_HALF;
        end
      end
      LPO_DBI_SETUP: begin
        next_dbi_state = LPO_DBI_STROBE;
        next_dbi_cnt = `LPO_DBI_HALF;
      end
      LPO_DBI_STROBE: begin
        // type b strobes low on wr/rd; type a drives wr and rd both low
        if (cfg_dbi_type_b_in) begin
          next_dbi_wr = dbi_rd_q;
          next_dbi_rd = !dbi_rd_q;
        end else begin
          next_dbi_wr = 1'b0;
          next_dbi_rd = 1'b0;
        end
        next_dbi_cnt = dbi_cnt - 3'h1;
        if (dbi_cnt == 3'h1) begin
          next_dbi_state = LPO_DBI_HOLD;
          // ack with the data, so idle never takes the same request twice
          next_ack = 1'b1;
          if (dbi_rd_q) begin
            next_rdata = dbi_d_s2;
          end
        end
      end
      default: begin
        // data stays driven one cycle past the strobe for hold time
        next_dbi_state = LPO_DBI_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      dbi_state <= LPO_DBI_IDLE;
      dbi_cnt <= 3'h0;
      dbi_d_out <= '0;
      dbi_d_oe_out <= 1'b0;
      dbi_dc_out <= 1'b0;
      dbi_wr_out <= 1'b1;
      dbi_rd_out <= 1'b1;
      dbi_ack_out <= 1'b0;
      dbi_rdata_out <= '0;
      dbi_rd_q <= 1'b0;
      vs_s1 <= 1'b0;
      vs_s2 <= 1'b0;
      dbi_busy_q <= 1'b0;
      dbi_d_s1 <= '0;
      dbi_d_s2 <= '0;
    end else begin
      dbi_state <= next_dbi_state;
      dbi_cnt <= next_dbi_cnt;
      dbi_d_out <= next_dbi_d;
      dbi_d_oe_out <= next_dbi_oe;
      dbi_dc_out <= next_dbi_dc;
      dbi_wr_out <= next_dbi_wr;
      dbi_rd_out <= next_dbi_rd;
      dbi_ack_out <= next_ack;
      dbi_rdata_out <= next_rdata;
      dbi_rd_q <= next_dbi_rd_q;
      vs_s1 <= lcd_vsync_out;
      vs_s2 <= vs_s1;
      dbi_busy_q <= (next_dbi_state != LPO_DBI_IDLE);
      dbi_d_s1 <= dbi_d_in;
      dbi_d_s2 <= dbi_d_s1;
    end
  end

  // -------------------------------------------------------------
  // panel register port, 3- or 4-wire
  // -------------------------------------------------------------
  lpo_spi_e spi_state, next_spi_state;
  logic [3:0] spi_div, next_spi_div;
  logic [4:0] spi_bits, next_spi_bits;
  logic [15:0] spi_sh, next_spi_sh;
  logic spi_rd_q, next_spi_rd_q;
  logic sda_s1, sda_s2;
  logic next_sck, next_cs_n, next_sda, next_sda_oe, next_busy, next_dc;
  logic [15:0] next_spi_rdata;

  always_comb begin
    next_spi_state = spi_state;
    next_spi_div = spi_div;
    next_spi_bits = spi_bits;
    next_spi_sh = spi_sh;
    next_spi_rd_q = spi_rd_q;
    next_sck = spi_sck_out;
    next_cs_n = spi_cs_n_out;
    next_sda = spi_sda_out;
    next_sda_oe = spi_sda_oe_out;
    next_dc = spi_dc_out;
    next_busy = spi_busy_out;
    next_spi_rdata = spi_rdata_out;
    case (spi_state)
      LPO_SPI_IDLE: begin
        next_sck = 1'b0;
        next_cs_n = 1'b1;
        next_sda_oe = 1'b0;
        if (spi_req_in) begin
          next_spi_state = LPO_SPI_SHIFT;
          next_spi_sh = spi_wdata_in;
          next_spi_rd_q = spi_rd_in;
          next_spi_bits = `LPO_SPI_BITS;
          next_spi_div = `LPO_SPI_DIV;
          next_cs_n = 1'b0;
          next_busy = 1'b1;
          // 4-wire: dc pin carries command flag from top data bit
          next_dc = cfg_spi_4wire_in & spi_wdata_in[15];
          next_sda = spi_wdata_in[15];
          next_sda_oe = 1'b1;
        end
      end
      LPO_SPI_SHIFT: begin
        next_spi_div = spi_div - 4'h1;
        if (spi_div == 4'h0) begin
          next_spi_div = `LPO_SPI_DIV;
          next_sck = !spi_sck_out;
          if (spi_sck_out) begin
            // falling edge: shift; read turns bus round after first byte
            next_spi_sh = {spi_sh[14:0], sda_s2};
            next_spi_bits = spi_bits - 5'h01;
            next_sda = spi_sh[14];
            next_sda_oe = !(spi_rd_q && spi_bits <= 5'h09);
            if (spi_bits == 5'h01) begin
              next_spi_state = LPO_SPI_DONE;
            end
          end
        end
      end
      default: begin
        next_spi_state = LPO_SPI_IDLE;
        next_cs_n = 1'b1;
        next_sda_oe = 1'b0;
        next_busy = 1'b0;
        next_spi_rdata = spi_rd_q ? {8'h00, spi_sh[7:0]} : spi_rdata_out;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      spi_state <= LPO_SPI_IDLE;
      spi_div <= 4'h0;
      spi_bits <= 5'h00;
      spi_sh <= 16'h0000;
      spi_rd_q <= 1'b0;
      spi_sck_out <= 1'b0;
      spi_cs_n_out <= 1'b1;
      spi_sda_out <= 1'b0;
      spi_sda_oe_out <= 1'b0;
      spi_dc_out <= 1'b0;
      spi_busy_out <= 1'b0;
      spi_rdata_out <= 16'h0000;
      sda_s1 <= 1'b0;
      sda_s2 <= 1'b0;
    end else begin
      spi_state <= next_spi_state;
      spi_div <= next_spi_div;
      spi_bits <= next_spi_bits;
      spi_sh <= next_spi_sh;
      spi_rd_q <= next_spi_rd_q;
      spi_sck_out <= next_sck;
      spi_cs_n_out <= next_cs_n;
      spi_sda_out <= next_sda;
      spi_sda_oe_out <= next_sda_oe;
      spi_dc_out <= next_dc;
      spi_busy_out <= next_busy;
      spi_rdata_out <= next_spi_rdata;
      sda_s1 <= spi_sda_in;
      sda_s2 <= sda_s1;
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  // pixel clock ceiling is a timing constraint on clk_pix_in, not logic
  property p_cs_exclusive;
    @(posedge clk_pix_in) disable iff (rst_in) !(!lcd_cs0_n_out && !lcd_cs1_n_out);
  endproperty
  a_cs_exclusive: assert property (p_cs_exclusive) else $error("both selects active");
  property p_ser4_dead;
    @(posedge clk_pix_in) disable iff (rst_in)
      (fmt_a == LPO_FMT_SER4 && beat == 2'h3) |=> (lcd_data_out == '0);
  endproperty
  a_ser4_dead: assert property (p_ser4_dead) else $error("fourth beat not blank");
  property p_ser3_wrap;
    @(posedge clk_pix_in) disable iff (rst_in)
      (fmt_a == LPO_FMT_SER3 && $stable(cfg_act) && beat == 2'h2) |=> (beat == 2'h0);
  endproperty
  a_ser3_wrap: assert property (p_ser3_wrap) else $error("three-cycle beat overrun");
  property p_ser_narrow;
    @(posedge clk_pix_in) disable iff (rst_in)
      (fmt_a != LPO_FMT_PAR) |=> (lcd_data_out[DW-1:8] == '0);
  endproperty
  a_ser_narrow: assert property (p_ser_narrow) else $error("serial format used upper lanes");
  property p_cfg_frame;
    @(posedge clk_pix_in) disable iff (rst_in)
      $changed(cfg_act) |-> ($rose(pix_vsync_in) || $past(pix_vsync_in && !vs_d));
  endproperty
  a_cfg_frame: assert property (p_cfg_frame) else $error("format changed mid frame");
  property p_interlace;
    @(posedge clk_pix_in) disable iff (rst_in)
      (pix_interlace_in && pix_line_odd_in != pix_field_odd_in) |=> !lcd_de_out;
  endproperty
  a_interlace: assert property (p_interlace) else $error("wrong field line shown");
  property p_progressive;
    @(posedge clk_pix_in) disable iff (rst_in)
      (!pix_interlace_in && pix_de_in) |=> lcd_de_out;
  endproperty
  a_progressive: assert property (p_progressive) else $error("progressive line dropped");
  property p_dbi_blank;
    @(posedge clk_sys_in) disable iff (rst_in)
      (dbi_state == LPO_DBI_IDLE && next_dbi_state == LPO_DBI_SETUP) |-> vs_s2;
  endproperty
  a_dbi_blank: assert property (p_dbi_blank) else $error("command bus outside blanking");
  property p_spi_len;
    @(posedge clk_sys_in) disable iff (rst_in)
      $rose(spi_busy_out) |-> ##128 spi_busy_out ##1 !spi_busy_out;
  endproperty
  a_spi_len: assert property (p_spi_len) else $error("register port length wrong");
endmodule : lpo_panel_out
`default_nettype wire

// ==== hdl/lpo_pkg.sv ====
// types for the lcd panel output interface
package lpo_pkg;
  typedef enum logic [2:0] {
    LPO_FMT_PAR = 3'b000,
    LPO_FMT_SER3 = 3'b001,
    LPO_FMT_SER4 = 3'b010,
    LPO_FMT_CCIR656 = 3'b011,
    LPO_FMT_CCIR601 = 3'b100
  } lpo_fmt_e;
  typedef enum logic [2:0] {
    LPO_BUS_24 = 3'b000,
    LPO_BUS_18 = 3'b001,
    LPO_BUS_16 = 3'b010,
    LPO_BUS_12 = 3'b011,
    LPO_BUS_8 = 3'b100
  } lpo_bus_e;
  typedef enum logic [1:0] {
    LPO_SPI_IDLE = 2'b00,
    LPO_SPI_SHIFT = 2'b01,
    LPO_SPI_DONE = 2'b10
  } lpo_spi_e;
  typedef enum logic [1:0] {
    LPO_DBI_IDLE = 2'b00,
    LPO_DBI_SETUP = 2'b01,
    LPO_DBI_STROBE = 2'b10,
    LPO_DBI_HOLD = 2'b11
  } lpo_dbi_e;
endpackage : lpo_pkg
